// file: include/sas_params.svh
/*
 * Constants for the speed alarm supervisor: limits, digit counts,
 * reset values and timing counts.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// ====================
// Timing
`define SAS_HALF_SEC_CYCLES 25000000
`define SAS_TIMEOUT_S 10
`define SAS_MAX_DELAY_S 3600

// ====================
// Entry formats and reset values
`define SAS_SPEED_DIGITS 7
`define SAS_HOURS_DIGITS 5
`define SAS_CODE_DIGITS 4
`define SAS_BYPASS_CODE 16'h0000
`define SAS_CODE_RESET 16'h0000
`define SAS_SP_RESET 28'h000_0000
`define SAS_HOURS_MASK 28'h00F_FFFF

`endif

// file: include/sas_pkg.sv
/*
 * Types shared by the speed alarm supervisor modules.
 * Assumes compilation before every design file.
 */
package sas_pkg;

    typedef logic [27:0] sas_bcd7_t;

    typedef enum logic [2:0] {
        SAS_DISPLAY,
        SAS_CODE_PROMPT,
        SAS_CODE_EDIT,
        SAS_SP_PROMPT,
        SAS_SP_EDIT
    } sas_menu_t;

endpackage

// file: verilog/sas_alarm_channel.sv
/*
 * One alarm channel: setpoint comparison, delay, silence, output.
 * Assumes ticks and accept pulses come from the same clock domain.
 */
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_alarm_channel (
    // Clock and pacing
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic half_tick,
    input wire logic sec_tick,
    input wire logic blink,
    // Configuration
    input wire logic enable,
    input wire logic type_speed,
    input wire logic high,
    input wire logic norm_closed,
    input wire logic [23:0] hysteresis,
    input wire logic [11:0] delay_s,
    input wire logic [15:0] silence_bcd,
    input wire sas_pkg::sas_bcd7_t setpoint,
    // Measurements and operator
    input wire logic [23:0] speed,
    input wire logic [16:0] hours,
    input wire logic accept,
    // Results
    output logic switch_closed,
    output logic annunciator,
    output logic active,
    output logic type_changed
);
    import sas_pkg::*;

    function automatic logic [23:0] bcd_to_bin(input sas_bcd7_t b);
        logic [23:0] acc;
        acc = 24'h00_0000;
        for (int i = 6; i >= 0; i--) begin
            acc = 24'(acc * 24'h00_000A) + {20'h0_0000, b[4*i +: 4]};
        end
        return acc;
    endfunction

    logic cond;
    logic type_q;
    logic primed;
    logic locked;
    logic silenced;
    logic tripped;
    logic armed;
    logic [11:0] dly_cnt;
    logic [11:0] dly_lim;
    logic [13:0] sil_cnt;
    logic [23:0] sil_bin;
    logic [24:0] value;
    logic [24:0] sp_bin;
    logic [24:0] hyst;

    assign dly_lim = (delay_s > 12'(`SAS_MAX_DELAY_S)) ?
        12'(`SAS_MAX_DELAY_S) : delay_s;
    assign sil_bin = bcd_to_bin({12'h000, silence_bcd});
    assign value = type_speed ? {1'b0, speed} : {8'h00, hours};
    assign sp_bin = {1'b0, bcd_to_bin(setpoint)};
    assign hyst = type_speed ? {1'b0, hysteresis} : 25'h000_0000;
    assign armed = enable & ~locked;
    assign tripped = cond & (dly_cnt >= dly_lim);

    // ====================
    // Type change locks the alarm off until it is disabled.
    always_ff @(posedge clk) begin
        if (srst) begin
            type_q <= 1'b1;
            primed <= 1'b0;
            locked <= 1'b0;
            type_changed <= 1'b0;
        end else if (ce) begin
            type_q <= type_speed;
            primed <= 1'b1;
            type_changed <= primed & (type_q != type_speed);
            if (primed & (type_q != type_speed)) begin
                locked <= 1'b1;
            end else if (!enable) begin
                locked <= 1'b0;
            end
        end
    end

    // ====================
    // Comparison, refreshed every half second.
    always_ff @(posedge clk) begin
        if (srst) begin
            cond <= 1'b0;
        end else if (ce) begin
            if (!armed) begin
                cond <= 1'b0;
            end else if (half_tick) begin
                if (high) begin
                    cond <= cond ? (value + hyst >= sp_bin) :
                        (value >= sp_bin);
                end else begin
                    cond <= cond ? (value <= sp_bin + hyst) :
                        (value <= sp_bin);
                end
            end
        end
    end

    // ====================
    // Delay and silence timers.
    always_ff @(posedge clk) begin
        if (srst) begin
            dly_cnt <= 12'h000;
        end else if (ce) begin
            if (!cond) begin
                dly_cnt <= 12'h000;
            end else if (sec_tick && dly_cnt < dly_lim) begin
                dly_cnt <= dly_cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            silenced <= 1'b0;
            sil_cnt <= 14'h0000;
        end else if (ce) begin
            if (!cond) begin
                silenced <= 1'b0;
                sil_cnt <= 14'h0000;
            end else if (!silenced) begin
                sil_cnt <= 14'h0000;
                if (accept && tripped && sil_bin != 24'h00_0000) begin
                    silenced <= 1'b1;
                end
            end else if (sec_tick) begin
                sil_cnt <= sil_cnt + 14'h0001;
                if (sil_cnt + 14'h0001 >= sil_bin[13:0]) begin
                    silenced <= 1'b0;
                end
            end
        end
    end

    // ====================
    // Output switch and annunciator.
    always_ff @(posedge clk) begin
        if (srst) begin
            active <= 1'b0;
            switch_closed <= 1'b0;
            annunciator <= 1'b0;
        end else if (ce) begin
            active <= tripped & ~silenced;
            switch_closed <= (tripped & ~silenced) ^ norm_closed;
            annunciator <= (tripped & ~silenced) |
                (cond & blink);
        end
    end

endmodule

// file: verilog/sas_supervisor.sv
/*
 * Speed alarm supervisor: two alarm channels, the direct setpoint
 * menu with its access code, digit editing and display flashing.
 * Assumes buttons arrive asynchronously from pins; measurements and
 * configuration come from logic on clk.
 */
// Behaviour
// - Hysteresis only on speed alarms.
// - High alarm: on at setpoint or above, off below it less hysteresis.
// - Delay in whole seconds, 0 to 3600.
// - Zero delay activates at once.
// - Lamp flashes during delay, then output on, lamp steady.
// - Nonzero silence time: programme press in display accepts.
// - Accept holds output at rest for the silence time.
// - Lamp flashes while silenced.
// - Silence time is decimal seconds.
// - Flash option alternates value and alarm id.
// - Programme plus up in display opens menu if enabled.
// - Menu refused while disabled.
// - Four-digit menu code; 0000 skips it.
// - New code adopted only in display mode.
// - Code prompt and digit entry precede setpoints.
// - Wrong code or ten idle seconds exit to display.
// - Up or down toggles first and second setpoint.
// - Prompt shows speed or hours by alarm type.
// - Flashing digit: up/down change, programme next, last stores.
// - Compare twice per second.
// - Speed setpoints seven digits, hours five.
// - Type change clears setpoint and disables alarm.
// - Output open or closed at rest, opposite when active.
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_supervisor #(
    parameter int unsigned HALF_SEC_CYCLES = `SAS_HALF_SEC_CYCLES
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Push buttons
    input wire logic btn_prog,
    input wire logic btn_up,
    input wire logic btn_down,
    // Measurements
    input wire logic [23:0] speed_value,
    input wire logic [16:0] runtime_hours,
    // Alarm configuration
    input wire logic [1:0] alarm_enable,
    input wire logic [1:0] speed_type,
    input wire logic [1:0] alarm_high,
    input wire logic [1:0] alarm_norm_closed,
    input wire logic [1:0][23:0] hysteresis_setting,
    input wire logic [1:0][11:0] activation_delay_setting,
    input wire logic [1:0][15:0] silence_time_bcd,
    input wire logic [1:0] display_flash_option,
    // Direct setpoint menu configuration
    input wire logic direct_setpoint_menu,
    input wire logic [15:0] access_code_entry,
    input wire logic [1:0] sp_load,
    input wire sas_pkg::sas_bcd7_t sp_load_value,
    // Alarm outputs
    output logic [1:0] alarm_switch,
    output logic [1:0] annunciator,
    // Menu and display
    output sas_pkg::sas_menu_t menu_state,
    output logic second_setpoint_prompt,
    output logic prompt_hours,
    output sas_pkg::sas_bcd7_t edit_value,
    output logic [2:0] edit_digit,
    output logic edit_blink,
    output logic show_alarm_id,
    output logic second_alarm_id,
    // Stored setpoints
    output sas_pkg::sas_bcd7_t first_setpoint,
    output sas_pkg::sas_bcd7_t second_setpoint
);
    import sas_pkg::*;

    localparam logic [24:0] HALF_LAST = 25'(HALF_SEC_CYCLES - 1);

    sas_menu_t next_state;
    sas_bcd7_t setpoint [2];

    logic [24:0] half_cnt;
    logic half_tick;
    logic phase;
    logic sec_tick;
    logic [2:0] btn_meta;
    logic [2:0] btn_sync;
    logic [2:0] btn_prev;
    logic [2:0] rise;
    logic prog_rise;
    logic up_rise;
    logic down_rise;
    logic combo;
    logic accept;
    logic [15:0] active_code;
    logic [3:0] idle_cnt;
    logic time_out;
    logic sel;
    logic last_digit;
    logic editing;
    logic store;
    logic [2:0] top_digit;
    logic [3:0] cur_digit;
    logic [1:0] ch_active;
    logic [1:0] ch_type_changed;
    logic [1:0] flashing;

    // ====================
    // Half-second and one-second pacing.
    always_ff @(posedge clk) begin
        if (srst) begin
            half_cnt <= 25'h000_0000;
            half_tick <= 1'b0;
        end else if (ce) begin
            half_tick <= (half_cnt == HALF_LAST);
            if (half_cnt == HALF_LAST) begin
                half_cnt <= 25'h000_0000;
            end else begin
                half_cnt <= half_cnt + 25'h000_0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 1'b0;
        end else if (ce && half_tick) begin
            phase <= ~phase;
        end
    end

    assign sec_tick = half_tick & phase;

    // ====================
    // Button synchronisers and press detection.
    always_ff @(posedge clk) begin
        if (srst) begin
            btn_meta <= 3'h0;
            btn_sync <= 3'h0;
            btn_prev <= 3'h0;
        end else if (ce) begin
            btn_meta <= {btn_down, btn_up, btn_prog};
            btn_sync <= btn_meta;
            btn_prev <= btn_sync;
        end
    end

    assign rise = btn_sync & ~btn_prev;
    assign prog_rise = rise[0];
    assign up_rise = rise[1];
    assign down_rise = rise[2];
    assign combo = btn_sync[0] & btn_sync[1] & (prog_rise | up_rise);
    assign accept = (menu_state == SAS_DISPLAY) & prog_rise &
        ~btn_sync[1];

    // ====================
    // Alarm channels.
    for (genvar i = 0; i < 2; i++) begin : g_ch
        sas_alarm_channel u_ch (
            .clk(clk),
            .srst(srst),
            .ce(ce),
            .half_tick(half_tick),
            .sec_tick(sec_tick),
            .blink(phase),
            .enable(alarm_enable[i]),
            .type_speed(speed_type[i]),
            .high(alarm_high[i]),
            .norm_closed(alarm_norm_closed[i]),
            .hysteresis(hysteresis_setting[i]),
            .delay_s(activation_delay_setting[i]),
            .silence_bcd(silence_time_bcd[i]),
            .setpoint(setpoint[i]),
            .speed(speed_value),
            .hours(runtime_hours),
            .accept(accept),
            .switch_closed(alarm_switch[i]),
            .annunciator(annunciator[i]),
            .active(ch_active[i]),
            .type_changed(ch_type_changed[i])
        );
    end

    // ====================
    // Access code, adopted only while in display mode.
    always_ff @(posedge clk) begin
        if (srst) begin
            active_code <= `SAS_CODE_RESET;
        end else if (ce && menu_state == SAS_DISPLAY) begin
            active_code <= access_code_entry;
        end
    end

    // ====================
    // Idle timeout inside the menu.
    always_ff @(posedge clk) begin
        if (srst) begin
            idle_cnt <= 4'h0;
        end else if (ce) begin
            if (menu_state == SAS_DISPLAY || rise != 3'h0) begin
                idle_cnt <= 4'h0;
            end else if (sec_tick && !time_out) begin
                idle_cnt <= idle_cnt + 4'h1;
            end
        end
    end

    assign time_out = (idle_cnt >= 4'(`SAS_TIMEOUT_S));

    // ====================
    // Menu sequencing.
    assign last_digit = (edit_digit == 3'h0);
    assign editing = (menu_state == SAS_CODE_EDIT) |
        (menu_state == SAS_SP_EDIT);
    assign store = (menu_state == SAS_SP_EDIT) & prog_rise & last_digit;

    always_comb begin
        next_state = menu_state;
        unique case (menu_state)
            SAS_DISPLAY: begin
                if (combo && direct_setpoint_menu) begin
                    next_state = (active_code == `SAS_BYPASS_CODE) ?
                        SAS_SP_PROMPT : SAS_CODE_PROMPT;
                end
            end
            SAS_CODE_PROMPT: begin
                if (prog_rise) begin
                    next_state = SAS_CODE_EDIT;
                end
            end
            SAS_CODE_EDIT: begin
                if (prog_rise && last_digit) begin
                    next_state = (edit_value[15:0] == active_code) ?
                        SAS_SP_PROMPT : SAS_DISPLAY;
                end
            end
            SAS_SP_PROMPT: begin
                if (combo) begin
                    next_state = SAS_DISPLAY;
                end else if (prog_rise) begin
                    next_state = SAS_SP_EDIT;
                end
            end
            SAS_SP_EDIT: begin
                if (store) begin
                    next_state = SAS_SP_PROMPT;
                end
            end
        endcase
        if (menu_state != SAS_DISPLAY && time_out) begin
            next_state = SAS_DISPLAY;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            menu_state <= SAS_DISPLAY;
        end else if (ce) begin
            menu_state <= next_state;
        end
    end

    // ====================
    // Setpoint prompt selection.
    always_ff @(posedge clk) begin
        if (srst) begin
            sel <= 1'b0;
        end else if (ce) begin
            if (menu_state == SAS_DISPLAY) begin
                sel <= 1'b0;
            end else if (menu_state == SAS_SP_PROMPT &&
                         (up_rise ^ down_rise)) begin
                sel <= ~sel;
            end
        end
    end

    // ====================
    // Digit editor.
    assign top_digit = speed_type[sel] ?
        3'(`SAS_SPEED_DIGITS - 1) : 3'(`SAS_HOURS_DIGITS - 1);
    assign cur_digit = edit_value[4*edit_digit +: 4];

    always_ff @(posedge clk) begin
        if (srst) begin
            edit_value <= `SAS_SP_RESET;
            edit_digit <= 3'h0;
        end else if (ce) begin
            if (menu_state == SAS_CODE_PROMPT && prog_rise) begin
                edit_value <= `SAS_SP_RESET;
                edit_digit <= 3'(`SAS_CODE_DIGITS - 1);
            end else if (menu_state == SAS_SP_PROMPT && prog_rise &&
                         !combo) begin
                edit_value <= setpoint[sel];
                edit_digit <= top_digit;
            end else if (editing) begin
                if (up_rise && !down_rise) begin
                    edit_value[4*edit_digit +: 4] <= (cur_digit == 4'h9) ?
                        4'h0 : cur_digit + 4'h1;
                end else if (down_rise && !up_rise) begin
                    edit_value[4*edit_digit +: 4] <= (cur_digit == 4'h0) ?
                        4'h9 : cur_digit - 4'h1;
                end else if (prog_rise && !last_digit) begin
                    edit_digit <= edit_digit - 3'h1;
                end
            end
        end
    end

    // ====================
    // Setpoint storage.
    always_ff @(posedge clk) begin
        if (srst) begin
            setpoint[0] <= `SAS_SP_RESET;
            setpoint[1] <= `SAS_SP_RESET;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if (ch_type_changed[i]) begin
                    setpoint[i] <= `SAS_SP_RESET;
                end else if (store && sel == 1'(i)) begin
                    setpoint[i] <= speed_type[i] ? edit_value :
                        (edit_value & `SAS_HOURS_MASK);
                end else if (sp_load[i]) begin
                    setpoint[i] <= speed_type[i] ? sp_load_value :
                        (sp_load_value & `SAS_HOURS_MASK);
                end
            end
        end
    end

    assign first_setpoint = setpoint[0];
    assign second_setpoint = setpoint[1];

    // ====================
    // Display indications.
    assign flashing = ch_active & display_flash_option;

    always_ff @(posedge clk) begin
        if (srst) begin
            second_setpoint_prompt <= 1'b0;
            prompt_hours <= 1'b0;
            edit_blink <= 1'b0;
            show_alarm_id <= 1'b0;
            second_alarm_id <= 1'b0;
        end else if (ce) begin
            second_setpoint_prompt <= sel;
            prompt_hours <= ~speed_type[sel];
            edit_blink <= editing & phase;
            show_alarm_id <= (menu_state == SAS_DISPLAY) &
                (flashing != 2'h0) & phase;
            second_alarm_id <= ~flashing[0];
        end
    end

endmodule

// file: tb/sas_supervisor_sva.sv
/*
 * Checker for sas_supervisor, attached to its ports by bind.
 * Assumes one clock, srst active high and ce held high.
 */
`timescale 1ns/1ps
module sas_supervisor_sva #(
    parameter int unsigned HALF_SEC_CYCLES = 8
) (
    // Clock, reset and buttons
    input wire logic clk,
    input wire logic srst,
    input wire logic btn_prog,
    input wire logic btn_up,
    input wire logic btn_down,
    // Configuration
    input wire logic [1:0] alarm_enable,
    input wire logic [1:0] speed_type,
    input wire logic [1:0] alarm_norm_closed,
    input wire logic [1:0] display_flash_option,
    input wire logic direct_setpoint_menu,
    // Outputs
    input wire logic [1:0] alarm_switch,
    input wire logic [1:0] annunciator,
    input wire sas_pkg::sas_menu_t menu_state,
    input wire logic second_setpoint_prompt,
    input wire logic prompt_hours,
    input wire sas_pkg::sas_bcd7_t edit_value,
    input wire logic [2:0] edit_digit,
    input wire logic edit_blink,
    input wire logic show_alarm_id,
    input wire sas_pkg::sas_bcd7_t first_setpoint,
    input wire sas_pkg::sas_bcd7_t second_setpoint
);
    import sas_pkg::*;
    // ====================
    // Idle time in the menu, bounded by the timeout plus two seconds and eight cycles.
    localparam int unsigned IDLE_MAX = 24 * HALF_SEC_CYCLES + 8;
    int unsigned idle;
    always_ff @(posedge clk) begin
        if (srst || menu_state == SAS_DISPLAY || btn_prog || btn_up
                || btn_down) begin
            idle <= 0;
        end else begin
            idle <= idle + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ====================
    // Properties
    a_menu_refused: assert property (
        menu_state == SAS_DISPLAY && !direct_setpoint_menu
        && !$past(direct_setpoint_menu) |=> menu_state == SAS_DISPLAY)
        else $error("menu opened while disabled");
    a_code_edit_start: assert property (
        menu_state == SAS_CODE_PROMPT ##1 menu_state == SAS_CODE_EDIT
        |-> edit_digit == 3'h3 && edit_value == 28'h000_0000)
        else $error("code entry did not start at top digit");
    a_sp_edit_digit: assert property (
        menu_state != SAS_SP_EDIT ##1 menu_state == SAS_SP_EDIT
        |-> edit_digit == (prompt_hours ? 3'h4 : 3'h6))
        else $error("wrong setpoint digit count");
    a_hours_prompt: assert property (
        menu_state == SAS_SP_PROMPT && $stable(menu_state)
        && $stable(second_setpoint_prompt)
        |-> prompt_hours == !speed_type[second_setpoint_prompt])
        else $error("prompt unit does not follow alarm type");
    a_menu_timeout: assert property (
        idle <= IDLE_MAX)
        else $error("menu stayed open without buttons");
    a_sp_store: assert property (
        menu_state == SAS_SP_EDIT ##1 menu_state == SAS_SP_PROMPT
        |-> (second_setpoint_prompt ? second_setpoint : first_setpoint)
        == $past(edit_value))
        else $error("edited setpoint not stored");
    a_disabled_rest: assert property (
        (!alarm_enable[0]) [*3] |-> !annunciator[0]
        && alarm_switch[0] == alarm_norm_closed[0])
        else $error("disabled alarm not at rest");
    a_blink_edit: assert property (
        !(menu_state inside {SAS_CODE_EDIT, SAS_SP_EDIT}) [*2]
        |-> !edit_blink)
        else $error("digit flashing outside editing");
    a_id_quiet: assert property (
        (display_flash_option == 2'h0) [*3] |-> !show_alarm_id)
        else $error("alarm id shown with flash option off");
    c_sp_edit: cover property (menu_state == SAS_SP_EDIT);
    c_code_exit: cover property (
        menu_state == SAS_CODE_EDIT ##1 menu_state == SAS_DISPLAY);
    c_alarm_on: cover property (alarm_switch[0] != alarm_norm_closed[0]);
endmodule

bind sas_supervisor sas_supervisor_sva #(
    .HALF_SEC_CYCLES(HALF_SEC_CYCLES)
) u_sva (.*);

// file: tb/sas_operator.sv
/*
 * Operator model: presses the push buttons on request.
 * Assumes the caller waits for each press to finish.
 */
`timescale 1ns/1ps
module sas_operator (
    // Clock
    input wire logic clk,
    // Push buttons
    output logic btn_prog = 1'b0,
    output logic btn_up = 1'b0,
    output logic btn_down = 1'b0
);
    // Holds and releases long enough for the two-stage synchroniser.
    task automatic press(input logic p, input logic u, input logic d);
        @(posedge clk);
        btn_prog <= p;
        btn_up <= u;
        btn_down <= d;
        repeat (6) @(posedge clk);
        {btn_prog, btn_up, btn_down} <= 3'h0;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule

// file: tb/sas_supervisor_tb_top.sv
/*
 * Self-checking bench for sas_supervisor: alarm table, delay,
 * silence and the direct setpoint menu.
 * Assumes sas_operator drives the buttons.
 */
`timescale 1ns/1ps
module sas_supervisor_tb_top;
    import sas_pkg::*;
    typedef struct {
        logic ch;
        logic hi;
        logic [23:0] val;
        logic ex;
    } sas_row_t;
    // ====================
    // Signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic btn_prog, btn_up, btn_down;
    logic [23:0] speed_value = 24'h0;
    logic [16:0] runtime_hours = 17'h0;
    logic [1:0] alarm_enable = 2'h0, speed_type = 2'h1, alarm_high = 2'h3;
    logic [1:0] alarm_norm_closed = 2'h2, display_flash_option = 2'h0;
    logic [1:0] sp_load = 2'h0;
    logic [1:0][23:0] hysteresis_setting = {24'hA, 24'hA};
    logic [1:0][11:0] activation_delay_setting = '0;
    logic [1:0][15:0] silence_time_bcd = '0;
    logic direct_setpoint_menu = 1'b0;
    logic [15:0] access_code_entry = 16'h0;
    sas_bcd7_t sp_load_value = 28'h0, edit_value;
    sas_bcd7_t first_setpoint, second_setpoint;
    logic [1:0] alarm_switch, annunciator;
    sas_menu_t menu_state;
    logic second_setpoint_prompt, prompt_hours, edit_blink;
    logic show_alarm_id, second_alarm_id;
    logic [2:0] edit_digit;
    int fails = 0, checks = 0, n, m;
    sas_row_t rows[11] = '{'{0,1,24'h18F,0}, '{0,1,24'h190,1},
        '{0,1,24'h186,1}, '{0,1,24'h185,0}, '{0,0,24'h191,0},
        '{0,0,24'h190,1}, '{0,0,24'h19A,1}, '{0,0,24'h19B,0},
        '{1,1,24'h63,0}, '{1,1,24'h64,1}, '{1,1,24'h5F,0}};

    sas_supervisor #(.HALF_SEC_CYCLES(8)) dut (.*);
    sas_operator op (.*);

    // ====================
    // Tasks
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input string s, input logic [27:0] got, exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic keys(input string s);
        foreach (s[i]) begin
            op.press(s[i] == "P" || s[i] == "C",
                s[i] == "U" || s[i] == "C", s[i] == "D");
        end
    endtask
    task automatic lamp_count(input int k);
        n = 0;
        m = 0;
        repeat (k) begin
            cyc(1);
            n += annunciator[0];
            m += show_alarm_id;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    // ====================
    // Main sequence
    initial begin
        cyc(6);
        check("sw_rst", alarm_switch, 2'h0);
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        cyc(2);
        check("menu_rst", menu_state, SAS_DISPLAY);
        check("sp_rst", first_setpoint, 28'h000_0000);
        @(posedge clk);
        sp_load <= 2'h1;
        sp_load_value <= 28'h000_0400;
        @(posedge clk);
        sp_load <= 2'h2;
        sp_load_value <= 28'h000_0100;
        @(posedge clk);
        sp_load <= 2'h0;
        alarm_enable <= 2'h3;
        cyc(40);
        foreach (rows[i]) begin
            @(posedge clk);
            alarm_high[rows[i].ch] <= rows[i].hi;
            if (rows[i].ch) begin
                runtime_hours <= rows[i].val[16:0];
            end else begin
                speed_value <= rows[i].val;
            end
            cyc(40);
            check("sw", alarm_switch[rows[i].ch],
                rows[i].ex ^ alarm_norm_closed[rows[i].ch]);
            check("lamp", annunciator[rows[i].ch], rows[i].ex);
        end
        $display("table done");
        @(posedge clk);
        alarm_high <= 2'h3;
        speed_value <= 24'h185;
        activation_delay_setting[0] <= 12'h2;
        display_flash_option <= 2'h1;
        cyc(40);
        @(posedge clk);
        speed_value <= 24'h1C2;
        cyc(12);
        check("dly_sw", alarm_switch[0], 1'b0);
        lamp_count(24);
        check("dly_lamp", n > 0 && n < 24, 1'b1);
        cyc(40);
        check("dly_on", alarm_switch[0], 1'b1);
        check("steady", annunciator[0], 1'b1);
        lamp_count(40);
        check("id", m > 0, 1'b1);
        check("id1", second_alarm_id, 1'b0);
        keys("P");
        check("no_acc", alarm_switch[0], 1'b1);
        $display("delay done");
        @(posedge clk);
        silence_time_bcd[0] <= 16'h0012;
        activation_delay_setting[0] <= 12'h0;
        cyc(2);
        keys("P");
        check("sil_sw", alarm_switch[0], 1'b0);
        lamp_count(30);
        check("sil_lamp", n > 0 && n < 30, 1'b1);
        cyc(120);
        check("sil_hold", alarm_switch[0], 1'b0);
        cyc(60);
        check("sil_end", alarm_switch[0], 1'b1);
        @(posedge clk);
        speed_value <= 24'h185;
        silence_time_bcd[0] <= 16'h0;
        cyc(40);
        $display("silence done");
        keys("C");
        check("refuse", menu_state, SAS_DISPLAY);
        @(posedge clk);
        direct_setpoint_menu <= 1'b1;
        keys("C");
        check("open", menu_state, SAS_SP_PROMPT);
        keys("U");
        check("sel2", second_setpoint_prompt, 1'b1);
        check("hours", prompt_hours, 1'b1);
        keys("DP");
        check("edit", menu_state, SAS_SP_EDIT);
        check("digit", edit_digit, 3'h6);
        check("load", edit_value, 28'h000_0400);
        keys("UPPPPPPP");
        check("store", first_setpoint, 28'h100_0400);
        check("back", menu_state, SAS_SP_PROMPT);
        keys("C");
        @(posedge clk);
        access_code_entry <= 16'h0012;
        keys("C");
        check("prompt", menu_state, SAS_CODE_PROMPT);
        keys("PPPUPUUP");
        check("good", menu_state, SAS_SP_PROMPT);
        keys("CCPPPPP");
        check("wrong", menu_state, SAS_DISPLAY);
        keys("C");
        cyc(100);
        check("wait", menu_state, SAS_CODE_PROMPT);
        cyc(150);
        check("tmo", menu_state, SAS_DISPLAY);
        $display("menu done");
        complete_run();
    end
endmodule
